//--- hw/cps_seq.sv
// Continuity pre-test sequencer top
`timescale 1ns/10ps
module cps_seq
    import cps_pkg::*;
#(
    parameter int unsigned MEAS_CYCLES   = MEAS_CYC,
    parameter int unsigned SETTLE_CYCLES = SETTLE_CYC,
    parameter int unsigned PULSE_CYCLES  = PULSE_CYC,
    parameter int unsigned BEEP_CYCLES   = BEEP_HALF_CYC
)(
    input  wire logic ref_clk,      // 200 MHz clock
    input  wire logic reset,        // Synchronous reset, also clears fail
    input  wire logic start_n,      // Operator start, active low pin
    input  wire logic ready,        // Ground-sense ready line, high = mismatch
    output cps_relay_t relay_q,     // Relay drive
    output logic      testing_q,    // Testing indicator
    output logic      fail_q,       // Fail output
    output logic      alarm_q,      // Alarm drive
    output logic      hv_start_q    // Start pulse to main controller
);

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    logic start_n_s;
    logic ready_s;

    cps_sync #(.RST_VAL(1'b1)) u_sync_start (
        .ref_clk (ref_clk),
        .reset   (reset),
        .d       (start_n),
        .q       (start_n_s)
    );

    cps_sync #(.RST_VAL(1'b0)) u_sync_ready (
        .ref_clk (ref_clk),
        .reset   (reset),
        .d       (ready),
        .q       (ready_s)
    );

    // ------------------------------------------------------------------
    // Start edge detector
    // ------------------------------------------------------------------
    logic start_prev_q;
    logic start_prev_d;
    logic start_fall;

    // History resets to the idle level of the pin, so a button held
    // through reset counts as a press once it passes the synchroniser
    always_comb
    begin
        start_prev_d = start_n_s;
        start_fall   = start_prev_q & ~start_n_s;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            start_prev_q <= 1'b1;
        end
        else
        begin
            start_prev_q <= start_prev_d;
        end
    end

    // ------------------------------------------------------------------
    // Interval end decode
    // ------------------------------------------------------------------
    localparam logic [CNT_W-1:0] MEAS_LAST   = CNT_W'(MEAS_CYCLES - 1);
    localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYCLES - 1);
    localparam logic [CNT_W-1:0] PULSE_LAST  = CNT_W'(PULSE_CYCLES - 1);
    localparam logic [CNT_W-1:0] BEEP_LAST   = CNT_W'(BEEP_CYCLES - 1);

    cps_state_t       state_q;
    cps_state_t       state_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic             meas_end;
    logic             settle_end;
    logic             pulse_end;

    always_comb
    begin
        meas_end   = (state_q == ST_MEAS) && (cnt_q == MEAS_LAST);
        settle_end = (state_q == ST_SETTLE) && (cnt_q == SETTLE_LAST);
        pulse_end  = (state_q == ST_PULSE) && (cnt_q == PULSE_LAST);
    end

    // ------------------------------------------------------------------
    // Interval counter
    // ------------------------------------------------------------------
    // One counter times all three intervals; it restarts from zero at
    // every boundary so each interval is exactly its own length
    always_comb
    begin
        cnt_d = '0;
        case (state_q)
            ST_MEAS:
            begin
                if (!meas_end)
                begin
                    cnt_d = cnt_q + CNT_W'(1);
                end
            end
            ST_SETTLE:
            begin
                if (!settle_end)
                begin
                    cnt_d = cnt_q + CNT_W'(1);
                end
            end
            ST_PULSE:
            begin
                if (!pulse_end)
                begin
                    cnt_d = cnt_q + CNT_W'(1);
                end
            end
            default:
            begin
                cnt_d = '0;
            end
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            cnt_q <= '0;
        end
        else
        begin
            cnt_q <= cnt_d;
        end
    end

    // ------------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
            begin
                if (start_fall)
                begin
                    state_d = ST_MEAS;
                end
            end
            ST_MEAS:
            begin
                // Ready is looked at once, as the measurement closes
                if (meas_end && ready_s)
                begin
                    state_d = ST_FAIL;
                end
                else if (meas_end)
                begin
                    state_d = ST_SETTLE;
                end
            end
            ST_SETTLE:
            begin
                if (settle_end)
                begin
                    state_d = ST_PULSE;
                end
            end
            ST_PULSE:
            begin
                if (pulse_end)
                begin
                    state_d = ST_IDLE;
                end
            end
            ST_FAIL:
            begin
                // Only reset leaves the fail latch; start is not looked at
                state_d = ST_FAIL;
            end
            default:
            begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            state_q <= ST_IDLE;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------------
    // Alarm cadence
    // ------------------------------------------------------------------
    logic [CNT_W-1:0] beep_q;
    logic [CNT_W-1:0] beep_d;
    logic             alarm_d;

    // Alarm sounds from the cycle the latch sets and toggles every
    // half period, so the beep rate is set by BEEP_CYCLES alone
    always_comb
    begin
        beep_d  = '0;
        alarm_d = 1'b0;
        case (state_q)
            ST_FAIL:
            begin
                if (beep_q == BEEP_LAST)
                begin
                    beep_d  = '0;
                    alarm_d = ~alarm_q;
                end
                else
                begin
                    beep_d  = beep_q + CNT_W'(1);
                    alarm_d = alarm_q;
                end
            end
            ST_MEAS:
            begin
                if (meas_end && ready_s)
                begin
                    alarm_d = 1'b1;
                end
            end
            default:
            begin
                beep_d  = '0;
                alarm_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            beep_q  <= '0;
            alarm_q <= 1'b0;
        end
        else
        begin
            beep_q  <= beep_d;
            alarm_q <= alarm_d;
        end
    end

    // ------------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------------
    cps_relay_t relay_d;
    logic       testing_d;
    logic       fail_d;
    logic       hv_start_d;

    // Outputs follow the state being entered, so each changes on the
    // same edge as the state while every port stays a flip-flop
    always_comb
    begin
        relay_d    = RELAY_NORMAL;
        testing_d  = testing_q;
        fail_d     = 1'b0;
        hv_start_d = 1'b0;
        case (state_d)
            ST_IDLE:
            begin
                relay_d = RELAY_NORMAL;
            end
            ST_MEAS:
            begin
                relay_d   = RELAY_MEAS;
                testing_d = 1'b0;
            end
            ST_SETTLE:
            begin
                // Probe relays stay in until the settling interval ends
                relay_d = RELAY_MEAS;
            end
            ST_PULSE:
            begin
                relay_d    = RELAY_NORMAL;
                hv_start_d = 1'b1;
                testing_d  = 1'b1;
            end
            ST_FAIL:
            begin
                fail_d    = 1'b1;
                testing_d = 1'b0;
            end
            default:
            begin
                relay_d = RELAY_NORMAL;
            end
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            relay_q    <= RELAY_NORMAL;
            testing_q  <= 1'b0;
            fail_q     <= 1'b0;
            hv_start_q <= 1'b0;
        end
        else
        begin
            relay_q    <= relay_d;
            testing_q  <= testing_d;
            fail_q     <= fail_d;
            hv_start_q <= hv_start_d;
        end
    end

endmodule : cps_seq

//--- hw/cps_pkg.sv
// Constants and types for the continuity pre-test sequencer
// Functional notes
// - Power-up: normal relays, ground sensing active
// - Start low begins one-second measurement
// - Measurement: split line/neutral, probe neutral
// - Testing indicator only after pre-check passes
// - Measurement end samples ready, sets fail
// - Fail latched: alarm pulses, fail asserted
// - Reset pulse clears fail and alarm
// - Pass starts one-second settling interval
// - Settling end restores normal relays
// - Settling end issues 20 ms start pulse
// - Controller start comes from this block
package cps_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ        = 200_000_000;
    localparam int unsigned MEAS_MS       = 1000;
    localparam int unsigned SETTLE_MS     = 1000;
    localparam int unsigned START_PULSE_MS = 20;
    localparam int unsigned BEEP_HALF_MS  = 333;
    localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
    localparam int unsigned MEAS_CYC      = MEAS_MS * CYC_PER_MS;
    localparam int unsigned SETTLE_CYC    = SETTLE_MS * CYC_PER_MS;
    localparam int unsigned PULSE_CYC     = START_PULSE_MS * CYC_PER_MS;
    localparam int unsigned BEEP_HALF_CYC = BEEP_HALF_MS * CYC_PER_MS;
    localparam int unsigned CNT_W         = 28;

    // ------------------------------------------------------------------
    // Relay drive
    // ------------------------------------------------------------------
    typedef struct packed {
        logic line_neutral_tie;   // Line tied to neutral
        logic ref_res_connect;    // Ground-sense reference in circuit
        logic line_return_tie;    // Line tied to return
        logic probe_connect;      // Probe through reference path to neutral
    } cps_relay_t;

    localparam cps_relay_t RELAY_NORMAL = 4'b1100;
    localparam cps_relay_t RELAY_MEAS   = 4'b0011;

    typedef enum logic [4:0] {
        ST_IDLE   = 5'b0_0001,
        ST_MEAS   = 5'b0_0010,
        ST_SETTLE = 5'b0_0100,
        ST_PULSE  = 5'b0_1000,
        ST_FAIL   = 5'b1_0000
    } cps_state_t;

endpackage : cps_pkg

//--- hw/cps_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module cps_sync
    import cps_pkg::*;
#(
    parameter logic RST_VAL = 1'b0
)(
    input  wire logic ref_clk,  // Clock
    input  wire logic reset,    // Synchronous reset
    input  wire logic d,        // Asynchronous input
    output logic      q         // Synchronised output
);
    logic meta_q;
    logic meta_d;
    logic q_d;

    always_comb
    begin
        meta_d = d;
        q_d    = meta_q;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            meta_q <= RST_VAL;
            q      <= RST_VAL;
        end
        else
        begin
            meta_q <= meta_d;
            q      <= q_d;
        end
    end
endmodule : cps_sync

//--- verif/cps_gnd_model.sv
// Ground-sense partner model driving the ready line
`timescale 1ns/10ps
module cps_gnd_model
    import cps_pkg::*;
(
    input  wire cps_relay_t relay_q,  // Relay drive from the sequencer
    input  wire logic       dut_ok,   // Leads of the unit under test tied
    output logic            ready     // High on impedance mismatch
);
    // Probe mode reports the lead check, normal sensing reports good ground
    assign ready = (relay_q == RELAY_MEAS) ? !dut_ok : 1'b0;
endmodule : cps_gnd_model

//--- verif/cps_seq_assertions.sv
// Port checker for the continuity pre-test sequencer
`timescale 1ns/10ps
module cps_seq_assertions
    import cps_pkg::*;
(
    input wire logic       ref_clk,     // Clock
    input wire logic       reset,       // Synchronous reset
    input wire logic       start_n,     // Operator start
    input wire logic       ready,       // Ground-sense ready
    input wire cps_relay_t relay_q,     // Relay drive
    input wire logic       testing_q,   // Testing indicator
    input wire logic       fail_q,      // Fail output
    input wire logic       alarm_q,     // Alarm drive
    input wire logic       hv_start_q   // Controller start pulse
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    sequence s_beep;
        alarm_q[*4] ##1 !alarm_q[*4] ##1 alarm_q;
    endsequence
    sequence s_pulse;
        hv_start_q[*5] ##1 !hv_start_q;
    endsequence
    property p_rst;
        $fell(reset) |-> relay_q == RELAY_NORMAL && !testing_q && !fail_q && !hv_start_q;
    endproperty
    property p_start;
        $fell(start_n) && relay_q == RELAY_NORMAL && !fail_q && !hv_start_q
            |-> ##[2:6] relay_q == RELAY_MEAS;
    endproperty
    property p_fail_cause;
        $rose(fail_q) |-> $past(relay_q) == RELAY_MEAS && relay_q == RELAY_NORMAL;
    endproperty
    property p_beep;
        $rose(fail_q) |-> s_beep;
    endproperty
    property p_hold;
        fail_q && !reset |=> fail_q;
    endproperty
    property p_quiet;
        !fail_q |-> !alarm_q;
    endproperty
    property p_test_ok;
        testing_q |-> !fail_q;
    endproperty
    property p_restore;
        $rose(hv_start_q) |-> testing_q && relay_q == RELAY_NORMAL
            && $past(relay_q) == RELAY_MEAS;
    endproperty
    property p_pulse;
        $rose(hv_start_q) |-> s_pulse;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    a_start: assert property (p_start) else $error("no measure after start");
    a_fail_cause: assert property (p_fail_cause) else $error("fail not at meas end");
    a_beep: assert property (p_beep) else $error("alarm cadence wrong");
    a_hold: assert property (p_hold) else $error("fail dropped");
    a_quiet: assert property (p_quiet) else $error("alarm without fail");
    a_test_ok: assert property (p_test_ok) else $error("testing with fail");
    a_restore: assert property (p_restore) else $error("relays not restored");
    a_pulse: assert property (p_pulse) else $error("start pulse width");
endmodule : cps_seq_assertions
bind cps_seq cps_seq_assertions chk (.ref_clk(ref_clk), .reset(reset), .start_n(start_n),
    .ready(ready), .relay_q(relay_q), .testing_q(testing_q), .fail_q(fail_q),
    .alarm_q(alarm_q), .hv_start_q(hv_start_q));

//--- verif/cps_seq_tb.sv
// Testbench for the continuity pre-test sequencer
`timescale 1ns/10ps
module cps_seq_tb;
    import cps_pkg::*;
    logic       ref_clk = 1'b0, reset = 1'b1, start_n = 1'b1, dut_ok = 1'b1;
    logic       ready, testing_q, fail_q, alarm_q, hv_start_q, last;
    cps_relay_t relay_q;
    int         error_cnt = 0, comparisons = 0, n, t;
    cps_seq #(.MEAS_CYCLES(20), .SETTLE_CYCLES(20), .PULSE_CYCLES(5), .BEEP_CYCLES(4)) dut (
        .ref_clk(ref_clk), .reset(reset), .start_n(start_n), .ready(ready),
        .relay_q(relay_q), .testing_q(testing_q), .fail_q(fail_q), .alarm_q(alarm_q),
        .hv_start_q(hv_start_q));
    cps_gnd_model gnd (.relay_q(relay_q), .dut_ok(dut_ok), .ready(ready));
    initial forever #2.5 ref_clk = ~ref_clk;
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick();
        @(posedge ref_clk);
        #1;
    endtask : tick
    task automatic test_pass();
        @(posedge ref_clk) start_n <= 1'b0;
        n = 0;
        while (hv_start_q !== 1'b1 && n < 100)
        begin
            @(posedge ref_clk);
            if (n == 3 || n == 25) start_n <= 1'b1;
            if (n == 20) start_n <= 1'b0;
            #1;
            n++;
            if (n == 12) chk(relay_q, RELAY_MEAS);
            if (hv_start_q !== 1'b1) chk(testing_q, 4'h0);
        end
        chk(4'(n >= 42 && n <= 47), 4'h1);
        chk(relay_q, RELAY_NORMAL);
        chk(testing_q, 4'h1);
        n = 0;
        while (hv_start_q === 1'b1 && n < 20)
        begin
            @(posedge ref_clk);
            if (n == 0) start_n <= 1'b0;
            #1;
            n++;
        end
        chk(4'(n), 4'h5);
        repeat (15) tick();
        chk(relay_q, RELAY_NORMAL);
        chk({hv_start_q, fail_q}, 4'h0);
        @(posedge ref_clk) start_n <= 1'b1;
        $display("test pass done");
    endtask : test_pass
    task automatic test_fail();
        @(posedge ref_clk) dut_ok <= 1'b0;
        start_n <= 1'b0;
        n = 0;
        while (fail_q !== 1'b1 && n < 60)
        begin
            tick();
            n++;
        end
        chk(fail_q, 4'h1);
        chk(testing_q, 4'h0);
        last = alarm_q;
        t = 0;
        repeat (16)
        begin
            tick();
            if (alarm_q !== last) t++;
            last = alarm_q;
        end
        chk(4'(t), 4'h4);
        @(posedge ref_clk) start_n <= 1'b1;
        @(posedge ref_clk) start_n <= 1'b0;
        repeat (30) tick();
        chk({fail_q, hv_start_q, testing_q}, 4'h4);
        @(posedge ref_clk) reset <= 1'b1;
        start_n <= 1'b1;
        dut_ok <= 1'b1;
        @(posedge ref_clk) reset <= 1'b0;
        tick();
        chk({fail_q, alarm_q}, 4'h0);
        chk(relay_q, RELAY_NORMAL);
        $display("test fail done");
    endtask : test_fail
    task automatic tally_and_finish();
        $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        #5000;
        error_cnt++;
        tally_and_finish();
    end
    initial
    begin
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        tick();
        chk(relay_q, RELAY_NORMAL);
        test_pass();
        test_fail();
        test_pass();
        tally_and_finish();
    end
endmodule : cps_seq_tb
